// ### core/evd_event_detect.sv
// Behaviour
// - The event input is checked continuously, at 2 Hz, at 1 Hz or at 1/4 Hz as the sample field selects.
// - The debounce field selects no filter with pull-up on, 3.9 ms, 15.625 ms or 31.25 ms of filtering.
// - Detection and time-stamp capture happen only while the detect enable bit is one.
// - Only the first event after the event flag is cleared is time stamped.
// - With halt-on-event set, a detected event stops the time-keeping counters.
// - A halted clock resumes after a valid write of the time registers, or while the detect enable bit is zero.
// - Halt-on-event clears itself once a write of the time registers completes.
// - Halting applies only while detection is enabled.
// - On battery, the detect output stays released when the battery disable bit is one.
// - The input pull-up is off when the pull-up disable bit is one and a debounce period is selected, and on otherwise.
// - A high input is an event that sets the flag, pulls the detect output low and stamps time.
// - The event flag clears on a written zero or on a status read with auto-clear on.
// - The time stamp holds six bytes at indices 14h to 19h, cleared only by power-up reset.
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "evd_regs.svh"

module evd_event_detect #(
  parameter int OscDivide = `EVD_TICK_DIV
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock side.
  input wire evd_pkg::evd_time_t rtcTime,
  input wire logic rtcTimeWritten,
  input wire logic onBattery,
  output logic rtcHalt,
  // Event pins.
  input wire logic eventInput,
  output logic eventPullupEnable,
  output logic eventDetectOut,
  output logic eventDetectOe_n,
  // Interrupt.
  output logic irq
);

  // --------------------------------------------------------------------------
  // Helper functions.
  // --------------------------------------------------------------------------

  // Debounce period in oscillator ticks for a selection.
  function automatic logic [10:0] debounceTicks(input logic [1:0] sel);
    unique case (sel)
      2'h1: debounceTicks = 11'(`EVD_DEB1_TICKS);
      2'h2: debounceTicks = 11'(`EVD_DEB2_TICKS);
      2'h3: debounceTicks = 11'(`EVD_DEB3_TICKS);
      2'h0: debounceTicks = 11'h000;
    endcase
  endfunction : debounceTicks

  // True when the divider chain sits at a sample instant of the chosen rate.
  function automatic logic sampleDue(input logic [1:0] sel, input logic [16:0] chain);
    unique case (sel)
      2'h1: sampleDue = (chain[`EVD_SMP_2HZ_LSB-1:0] == '0);
      2'h2: sampleDue = (chain[`EVD_SMP_1HZ_LSB-1:0] == '0);
      2'h3: sampleDue = (chain[`EVD_SMP_QHZ_LSB-1:0] == '0);
      2'h0: sampleDue = 1'b1;
    endcase
  endfunction : sampleDue

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  logic [12:0] divCnt_reg, divCnt_next;
  logic oscTick_reg, oscTick_next;
  logic [16:0] chain_reg, chain_next;
  logic [10:0] highCnt_reg, highCnt_next;
  evd_pkg::evd_ctrl_t ctrl_reg, ctrl_next;
  logic eventFlag_reg, eventFlag_next;
  logic halted_reg, halted_next;
  evd_pkg::evd_time_t stamp_reg, stamp_next;
  logic [1:0] irqStat_reg, irqStat_next;
  logic [1:0] irqMask_reg, irqMask_next;
  evd_pkg::evd_addr_t addr_reg, addr_next;
  logic [31:0] hrdata_next;
  logic rtcHalt_next, pullup_next, detOe_n_next, irq_next;
  logic qualified, eventNow, wrCtrl, wrStat, wrIrq, wrMask, rdStat;

  // --------------------------------------------------------------------------
  // Oscillator time base and divider chain.
  // --------------------------------------------------------------------------

  // Derives a 32.768 kHz tick from the system clock and counts it.
  always_comb begin
    oscTick_next = (divCnt_reg == 13'(OscDivide - 1));
    divCnt_next = oscTick_next ? 13'h0000 : divCnt_reg + 13'h0001;
    chain_next = oscTick_reg ? chain_reg + 17'h00001 : chain_reg;
  end

  // --------------------------------------------------------------------------
  // Debounce filter and event qualification.
  // --------------------------------------------------------------------------

  // Counts oscillator ticks of continuous high input, saturating at the period.
  always_comb begin
    highCnt_next = highCnt_reg;
    if (!eventInput) begin
      highCnt_next = 11'h000;
    end else if (oscTick_reg && highCnt_reg < debounceTicks(ctrl_reg.eventDebounceSel)) begin
      highCnt_next = highCnt_reg + 11'h001;
    end
  end

  // An event is a qualified high seen at a sample instant while enabled.
  always_comb begin
    if (ctrl_reg.eventDebounceSel == 2'h0) begin
      qualified = eventInput;
    end else begin
      qualified = eventInput && (highCnt_reg >= debounceTicks(ctrl_reg.eventDebounceSel));
    end
    eventNow = ctrl_reg.detectEnable && qualified &&
      (ctrl_reg.eventSampleRateSel == 2'h0 ||
       (oscTick_reg && sampleDue(ctrl_reg.eventSampleRateSel, chain_reg)));
  end

  // --------------------------------------------------------------------------
  // AHB-Lite decode.
  // --------------------------------------------------------------------------

  // Latches each accepted address phase for its data phase.
  always_comb begin
    addr_next.valid = hsel && htrans[1] && hready;
    addr_next.write = hwrite;
    addr_next.index = haddr[9:2];
    wrCtrl = addr_reg.valid && addr_reg.write && addr_reg.index == `EVD_IDX_CTRL;
    wrStat = addr_reg.valid && addr_reg.write && addr_reg.index == `EVD_IDX_STATUS;
    wrIrq = addr_reg.valid && addr_reg.write && addr_reg.index == `EVD_IDX_IRQ_STAT;
    wrMask = addr_reg.valid && addr_reg.write && addr_reg.index == `EVD_IDX_IRQ_MASK;
    rdStat = addr_next.valid && !hwrite && haddr[9:2] == `EVD_IDX_STATUS;
  end

  // Read data is fetched in the address phase and stands in the data phase.
  always_comb begin
    hrdata_next = 32'h0000_0000;
    if (addr_next.valid && !hwrite) begin
      unique case (haddr[9:2])
        `EVD_IDX_CTRL: hrdata_next = {23'h000000, ctrl_reg};
        `EVD_IDX_STATUS: hrdata_next = {30'h00000000, halted_reg, eventFlag_reg};
        `EVD_IDX_IRQ_STAT: hrdata_next = {30'h00000000, irqStat_reg};
        `EVD_IDX_IRQ_MASK: hrdata_next = {30'h00000000, irqMask_reg};
        `EVD_IDX_TS_SEC: hrdata_next = {24'h000000, stamp_reg.seconds};
        `EVD_IDX_TS_MIN: hrdata_next = {24'h000000, stamp_reg.minutes};
        `EVD_IDX_TS_HOUR: hrdata_next = {24'h000000, stamp_reg.hours};
        `EVD_IDX_TS_DATE: hrdata_next = {24'h000000, stamp_reg.date};
        `EVD_IDX_TS_MONTH: hrdata_next = {24'h000000, stamp_reg.month};
        `EVD_IDX_TS_YEAR: hrdata_next = {24'h000000, stamp_reg.year};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Control, flag, time stamp and halt.
  // --------------------------------------------------------------------------

  // Software writes, flag clearing with set winning, stamp capture and halt.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrCtrl) begin
      ctrl_next = evd_pkg::evd_ctrl_t'(hwdata[8:0]);
    end
    if (rtcTimeWritten) begin
      ctrl_next.haltClockOnEvent = 1'b0;
    end
    eventFlag_next = eventFlag_reg;
    if ((wrStat && !hwdata[`EVD_STAT_EVENT]) || (rdStat && ctrl_reg.autoClearOnRead)) begin
      eventFlag_next = 1'b0;
    end
    if (eventNow) begin
      eventFlag_next = 1'b1;
    end
    stamp_next = stamp_reg;
    if (eventNow && !eventFlag_reg) begin
      stamp_next = rtcTime;
    end
    halted_next = halted_reg;
    if (eventNow && ctrl_reg.haltClockOnEvent) begin
      halted_next = 1'b1;
    end else if (rtcTimeWritten) begin
      halted_next = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status, mask and pin outputs.
  // --------------------------------------------------------------------------

  // Sticky events cleared by writing one; new events win over the clear.
  always_comb begin
    irqStat_next = irqStat_reg;
    if (wrIrq) begin
      irqStat_next = irqStat_reg & ~hwdata[1:0];
    end
    if (eventNow && !eventFlag_reg) begin
      irqStat_next[`EVD_IRQ_EVENT] = 1'b1;
    end
    if (halted_reg && rtcTimeWritten) begin
      irqStat_next[`EVD_IRQ_RESUME] = 1'b1;
    end
    irqMask_next = wrMask ? hwdata[1:0] : irqMask_reg;
    irq_next = |(irqStat_next & irqMask_next);
    rtcHalt_next = halted_next && ctrl_next.detectEnable;
    pullup_next = !ctrl_next.eventPullupDisable || ctrl_next.eventDebounceSel == 2'h0;
    detOe_n_next = !(eventFlag_next &&
      !(onBattery && ctrl_next.eventOutputBatteryDisable));
  end

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------

  // Time base: the tick divider and the divider chain that times sampling.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_reg <= 13'h0000;
      oscTick_reg <= 1'b0;
      chain_reg <= 17'h00000;
    end else begin
      divCnt_reg <= divCnt_next;
      oscTick_reg <= oscTick_next;
      chain_reg <= chain_next;
    end
  end

  // Debounce counter of continuous high input.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      highCnt_reg <= 11'h000;
    end else begin
      highCnt_reg <= highCnt_next;
    end
  end

  // Bus address latch and the slave's answer.
  // The slave never stretches a transfer and never signals an error, so
  // ready and response are constant flops that keep the outputs registered.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      hrdata <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Control, event flag, halt and the time stamp.
  // The stamp is cleared only by the power-up reset, never by software.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= evd_pkg::evd_ctrl_t'(`EVD_CTRL_RESET);
      eventFlag_reg <= 1'b0;
      halted_reg <= 1'b0;
      stamp_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      eventFlag_reg <= eventFlag_next;
      halted_reg <= halted_next;
      stamp_reg <= stamp_next;
    end
  end

  // Interrupt state and the pin outputs.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_reg <= 2'h0;
      irqMask_reg <= 2'h0;
      rtcHalt <= 1'b0;
      eventPullupEnable <= 1'b1;
      eventDetectOut <= 1'b0;
      eventDetectOe_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      rtcHalt <= rtcHalt_next;
      eventPullupEnable <= pullup_next;
      eventDetectOut <= 1'b0; // Open drain: only ever pulls low.
      eventDetectOe_n <= detOe_n_next;
      irq <= irq_next;
    end
  end

endmodule : evd_event_detect

`default_nettype wire

// ### pkg/evd_regs.svh
`ifndef EVD_REGS_SVH
`define EVD_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------------
`define EVD_IDX_CTRL 8'h00
`define EVD_IDX_STATUS 8'h01
`define EVD_IDX_IRQ_STAT 8'h02
`define EVD_IDX_IRQ_MASK 8'h03
`define EVD_IDX_TS_SEC 8'h14
`define EVD_IDX_TS_MIN 8'h15
`define EVD_IDX_TS_HOUR 8'h16
`define EVD_IDX_TS_DATE 8'h17
`define EVD_IDX_TS_MONTH 8'h18
`define EVD_IDX_TS_YEAR 8'h19

// ----------------------------------------------------------------------------
// Control register field positions and reset values.
// ----------------------------------------------------------------------------
`define EVD_CTRL_SAMPLE_LSB 0
`define EVD_CTRL_DEBOUNCE_LSB 2
`define EVD_CTRL_ENABLE 4
`define EVD_CTRL_HALT 5
`define EVD_CTRL_BATT_DIS 6
`define EVD_CTRL_PULLUP_DIS 7
`define EVD_CTRL_AUTOCLR 8
`define EVD_CTRL_RESET 9'h000
`define EVD_STAT_EVENT 0
`define EVD_IRQ_EVENT 0
`define EVD_IRQ_RESUME 1

// ----------------------------------------------------------------------------
// Timing: system clock, oscillator time base and debounce periods.
// ----------------------------------------------------------------------------
`define EVD_CLK_HZ 200000000
`define EVD_OSC_HZ 32768
`define EVD_TICK_DIV (`EVD_CLK_HZ / `EVD_OSC_HZ)
`define EVD_DEB1_US 3900
`define EVD_DEB2_US 15625
`define EVD_DEB3_US 31250
`define EVD_US_TO_TICKS(us) (((us) * `EVD_OSC_HZ + 999999) / 1000000)
`define EVD_DEB1_TICKS `EVD_US_TO_TICKS(`EVD_DEB1_US)
`define EVD_DEB2_TICKS `EVD_US_TO_TICKS(`EVD_DEB2_US)
`define EVD_DEB3_TICKS `EVD_US_TO_TICKS(`EVD_DEB3_US)
`define EVD_SMP_2HZ_LSB 14
`define EVD_SMP_1HZ_LSB 15
`define EVD_SMP_QHZ_LSB 17

`endif

// ### pkg/evd_pkg.sv
// ----------------------------------------------------------------------------
// Types shared by the event detect block.
// ----------------------------------------------------------------------------
`default_nettype none

package evd_pkg;

  // Calendar time as six bytes, day of week left out.
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } evd_time_t;

  // Software controls of the event detector.
  typedef struct packed {
    logic autoClearOnRead;
    logic eventPullupDisable;
    logic eventOutputBatteryDisable;
    logic haltClockOnEvent;
    logic detectEnable;
    logic [1:0] eventDebounceSel;
    logic [1:0] eventSampleRateSel;
  } evd_ctrl_t;

  // Latched AHB address phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
  } evd_addr_t;

endpackage : evd_pkg

`default_nettype wire

// ### verification/evd_event_detect_props.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Port checker.
// ----
module evd_event_detect_props (
  // Clock, reset and bus.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Clock side and pins.
  input wire logic rtcTimeWritten,
  input wire logic onBattery,
  input wire logic rtcHalt,
  input wire logic eventInput,
  input wire logic eventPullupEnable,
  input wire logic eventDetectOut,
  input wire logic eventDetectOe_n
);
  logic take;
  logic ctrlWr_reg;
  logic [7:0] inHist_reg;
  evd_pkg::evd_ctrl_t ctrl_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // An accepted address phase.
  assign take = hsel && htrans[1] && hready;
  // Shadow of the control word and a short history of the event pin.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlWr_reg <= 1'b0;
      ctrl_reg <= '0;
      inHist_reg <= '0;
    end else begin
      ctrlWr_reg <= take && hwrite && (haddr == 32'h00000000);
      if (ctrlWr_reg) begin
        ctrl_reg <= evd_pkg::evd_ctrl_t'(hwdata[8:0]);
      end
      inHist_reg <= {inHist_reg[6:0], eventInput};
    end
  end
  property p_bus; take |=> hreadyout && !hresp; endproperty
  property p_rdzero; !(take && !hwrite) |=> hrdata == 32'h00000000; endproperty
  property p_od; eventDetectOut == 1'b0; endproperty
  property p_pullup;
    $stable(ctrl_reg)[*3] |->
      eventPullupEnable == !(ctrl_reg.eventPullupDisable && ctrl_reg.eventDebounceSel != 2'h0);
  endproperty
  property p_nohalt; (!ctrl_reg.detectEnable)[*3] |-> !rtcHalt; endproperty
  property p_resume;
    rtcTimeWritten && !eventInput && inHist_reg == 8'h00 |-> ##[1:2] !rtcHalt;
  endproperty
  property p_cause;
    $fell(eventDetectOe_n) |-> inHist_reg != 8'h00 && ctrl_reg.detectEnable;
  endproperty
  property p_batt;
    (onBattery && ctrl_reg.eventOutputBatteryDisable)[*3] |-> eventDetectOe_n;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer wrong");
  a_rdzero: assert property (p_rdzero) else $error("read data not zero");
  a_od: assert property (p_od) else $error("detect pin driven high");
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");
  a_nohalt: assert property (p_nohalt) else $error("halt while disabled");
  a_resume: assert property (p_resume) else $error("no resume");
  a_cause: assert property (p_cause) else $error("detect without event");
  a_batt: assert property (p_batt) else $error("detect on battery");
  c_halt: cover property ($rose(rtcHalt));
  c_detect: cover property ($fell(eventDetectOe_n));
  c_batt: cover property (onBattery && !eventDetectOe_n);
endmodule : evd_event_detect_props
bind evd_event_detect evd_event_detect_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .rtcTimeWritten(rtcTimeWritten), .onBattery(onBattery), .rtcHalt(rtcHalt),
  .eventInput(eventInput), .eventPullupEnable(eventPullupEnable),
  .eventDetectOut(eventDetectOut), .eventDetectOe_n(eventDetectOe_n));
`default_nettype wire

// ### verification/evd_event_sensor.sv
`timescale 1ns/100ps
`default_nettype none
// Tamper switch to ground on the event pin, and the pulled-up detect line.
module evd_event_sensor (
  // Switch state.
  input wire logic switchOpen,
  // Block pins.
  input wire logic eventPullupEnable,
  input wire logic eventDetectOut,
  input wire logic eventDetectOe_n,
  output logic eventInput,
  output logic detectPin
);
  // An open switch leaves the pin to the pull-up; without it the pin leaks low.
  assign eventInput = switchOpen && eventPullupEnable;
  // The detect line is high unless the block pulls it low.
  assign detectPin = eventDetectOe_n ? 1'b1 : eventDetectOut;
endmodule : evd_event_sensor
`default_nettype wire

// ### verification/event_detect_timestamp_control_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "evd_regs.svh"
module event_detect_timestamp_control_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rdPhase = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic rtcTimeWritten = 1'b0;
  logic onBattery = 1'b0;
  logic switchOpen = 1'b0;
  logic [31:0] seed = 32'h0000977d;
  evd_pkg::evd_time_t rtcTime = '0;
  evd_pkg::evd_time_t stamp;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rtcHalt, eventInput, eventPullupEnable;
  logic eventDetectOut, eventDetectOe_n, irq, detectPin;
  logic [31:0] expQ[$];
  int fails = 0;
  int compares = 0;
  evd_event_detect #(.OscDivide(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rtcTime(rtcTime), .rtcTimeWritten(rtcTimeWritten), .onBattery(onBattery),
    .rtcHalt(rtcHalt), .eventInput(eventInput), .eventPullupEnable(eventPullupEnable),
    .eventDetectOut(eventDetectOut), .eventDetectOe_n(eventDetectOe_n), .irq(irq));
  evd_event_sensor u_sensor (.switchOpen(switchOpen), .eventPullupEnable(eventPullupEnable),
    .eventDetectOut(eventDetectOut), .eventDetectOe_n(eventDetectOe_n),
    .eventInput(eventInput), .detectPin(detectPin));
  // Clock at 200 MHz.
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One single AHB transfer; a read notes its expected word.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                     input logic [31:0] e);
    haddr <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rdPhase <= !wr;
    if (!wr) expQ.push_back(e);
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdPhase <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 32'h00000000);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h00000000, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // Compares each completed read with the oldest note.
  always @(posedge sys_clk) begin
    if (rdPhase && hreadyout === 1'b1) begin
      chk("hrdata", hrdata, expQ.pop_front());
    end
  end
  // Watchdog.
  initial begin
    #300us;
    fails++;
    test_done();
  end
  // Main sequence.
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    chk("pullup", eventPullupEnable, 32'h1);
    rd(`EVD_IDX_CTRL, 32'h0);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 6; i++) rd(8'(`EVD_IDX_TS_SEC + i), 32'h0);
    $display("reset test done");
    seed = xs(seed);
    rtcTime <= {seed[15:0], seed};
    wr(`EVD_IDX_CTRL, 32'h20);
    switchOpen <= 1'b1;
    tick(50);
    rd(`EVD_IDX_STATUS, 32'h0);
    chk("halt", rtcHalt, 32'h0);
    for (int i = 1; i < 4; i++) begin
      wr(`EVD_IDX_CTRL, 32'h10 | i);
      tick(2000);
      rd(`EVD_IDX_STATUS, 32'h0);
    end
    switchOpen <= 1'b0;
    $display("disable and rate test done");
    wr(`EVD_IDX_IRQ_MASK, 32'h3);
    wr(`EVD_IDX_CTRL, 32'h34);
    stamp = rtcTime;
    switchOpen <= 1'b1;
    tick(300);
    switchOpen <= 1'b0;
    tick(20);
    rd(`EVD_IDX_STATUS, 32'h0);
    switchOpen <= 1'b1;
    tick(600);
    rd(`EVD_IDX_STATUS, 32'h3);
    chk("detect", detectPin, 32'h0);
    chk("halt", rtcHalt, 32'h1);
    chk("irq", irq, 32'h1);
    seed = xs(seed);
    rtcTime <= {seed, seed[31:16]};
    tick(10);
    for (int i = 0; i < 6; i++) begin
      rd(8'(`EVD_IDX_TS_SEC + i), {24'h000000, stamp[8 * i +: 8]});
    end
    switchOpen <= 1'b0;
    tick(10);
    wr(`EVD_IDX_STATUS, 32'h1);
    rd(`EVD_IDX_STATUS, 32'h3);
    wr(`EVD_IDX_STATUS, 32'h0);
    rd(`EVD_IDX_STATUS, 32'h2);
    switchOpen <= 1'b1;
    tick(600);
    rd(`EVD_IDX_TS_YEAR, {24'h000000, rtcTime.year});
    switchOpen <= 1'b0;
    tick(20);
    rtcTimeWritten <= 1'b1;
    tick(1);
    rtcTimeWritten <= 1'b0;
    tick(4);
    chk("halt", rtcHalt, 32'h0);
    rd(`EVD_IDX_CTRL, 32'h14);
    rd(`EVD_IDX_IRQ_STAT, 32'h3);
    wr(`EVD_IDX_IRQ_STAT, 32'h3);
    tick(3);
    chk("irq", irq, 32'h0);
    $display("stamp and halt test done");
    wr(`EVD_IDX_STATUS, 32'h0);
    wr(`EVD_IDX_IRQ_MASK, 32'h2);
    wr(`EVD_IDX_CTRL, 32'h110);
    switchOpen <= 1'b1;
    tick(10);
    switchOpen <= 1'b0;
    tick(10);
    rd(`EVD_IDX_STATUS, 32'h1);
    rd(`EVD_IDX_STATUS, 32'h0);
    chk("irq", irq, 32'h0);
    wr(`EVD_IDX_IRQ_MASK, 32'h3);
    tick(3);
    chk("irq", irq, 32'h1);
    $display("auto clear test done");
    onBattery <= 1'b1;
    wr(`EVD_IDX_CTRL, 32'h50);
    switchOpen <= 1'b1;
    tick(10);
    chk("detect", detectPin, 32'h1);
    wr(`EVD_IDX_CTRL, 32'h10);
    tick(3);
    chk("detect", detectPin, 32'h0);
    switchOpen <= 1'b0;
    tick(10);
    wr(`EVD_IDX_STATUS, 32'h0);
    wr(`EVD_IDX_CTRL, 32'h94);
    tick(3);
    chk("pullup", eventPullupEnable, 32'h0);
    switchOpen <= 1'b1;
    tick(600);
    rd(`EVD_IDX_STATUS, 32'h0);
    wr(`EVD_IDX_CTRL, 32'h14);
    tick(600);
    rd(`EVD_IDX_STATUS, 32'h1);
    $display("battery and pull-up test done");
    test_done();
  end
endmodule : event_detect_timestamp_control_test
`default_nettype wire
